// file: verilog/monitor_config_pkg.sv
// Package with the addresses, field positions and timing counts of the monitor configuration slice.
package monitor_config_pkg;
  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [7:0] ADDR_STEP14_RESULT = 8'h2e;
  localparam logic [7:0] ADDR_STEP15_RESULT = 8'h2f;
  localparam logic [7:0] ADDR_MONITOR_CONFIG = 8'h40;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] READ_UNMAPPED = 16'h0000;
  // Writable bits 15:12, 8, 2:0; reserved bits 11:9 and 7:3 stay zero.
  localparam logic [15:0] CONFIG_WRITE_MASK = 16'hf107;

  // ***************************************************************
  // Field positions of the monitor configuration register
  // ***************************************************************
  localparam int BIT_SECTION1_CRC_EN = 15;
  localparam int BIT_CRC_TYPE = 14;
  localparam int BIT_SCLK_COUNTER_EN = 13;
  localparam int BIT_TIMEOUT_EN = 12;
  localparam int BIT_FAULT_POLARITY = 8;
  localparam int BIT_HOST_LOSS_POLARITY = 2;
  localparam int WINDOW_HI = 1;
  localparam int WINDOW_LO = 0;

  // ***************************************************************
  // Timing, counted in internal oscillator cycles
  // ***************************************************************
  localparam int TIMER_WIDTH = 15;
  localparam int CS_TIMEOUT_CYCLES = 16384;
  localparam int WINDOW_SHORT_CYCLES = 5120;
  localparam int WINDOW_MID_CYCLES = 10240;
  localparam int WINDOW_LONG_CYCLES = 20480;

  // Watchdog window codes.
  typedef enum logic [1:0]
  {
    WINDOW_OFF = 2'b00,
    WINDOW_SHORT = 2'b01,
    WINDOW_MID = 2'b10,
    WINDOW_LONG = 2'b11
  } host_window_t;
endpackage

// file: verilog/cycle_timer.sv
// Restartable cycle counter that flags when a programmed limit is reached.
`timescale 1ns/100ps
module cycle_timer
  import monitor_config_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic restart,
  input wire logic [monitor_config_pkg::TIMER_WIDTH-1:0] limit,
  output logic done_q
);
  import monitor_config_pkg::*;

  logic [TIMER_WIDTH-1:0] count_q;
  logic [TIMER_WIDTH-1:0] count_d;
  logic done_d;

  // Count while running; done rises when limit cycles have elapsed and holds until restart.
  always_comb
  begin
    count_d = count_q;
    done_d = done_q;
    if (restart)
    begin
      count_d = '0;
      done_d = 1'b0;
    end
    else if (run && !done_q)
    begin
      count_d = count_q + 1'b1;
      if (count_d == limit)
      begin
        done_d = 1'b1;
      end
    end
  end

  // State registers.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      count_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      done_q <= done_d;
    end
  end
endmodule

// file: verilog/monitor_config_regs.sv
// Converter result registers, device monitor configuration, fault pin, frame timeout and host-loss watchdog.
//
// Contract
// - Read-only result of converter B step 14 at 2Eh, reset zero.
// - Read-only result of converter B step 15 at 2Fh, reset zero.
// - Both results are signed two's complement across bits 15 to 0.
// - Monitor configuration at 40h resets to zero, all features off.
// - Bit 15 enables CRC over register section 40h to 59h.
// - Bit 14 picks CRC polynomial: 0 CCITT, 1 ANSI; host must match.
// - Bit 13 enables the serial clock edge counter.
// - Bit 12: chip select low too long drops rest of frame.
// - Fault output active on any unmasked fault; bit 8 sets level.
// - Watchdog flags host loss without valid command; window bits 1:0, polarity bit 2.
`timescale 1ns/100ps
module monitor_config_regs
  import monitor_config_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = monitor_config_pkg::CS_TIMEOUT_CYCLES,
  parameter int WD_SHORT_CYCLES = monitor_config_pkg::WINDOW_SHORT_CYCLES,
  parameter int WD_MID_CYCLES = monitor_config_pkg::WINDOW_MID_CYCLES,
  parameter int WD_LONG_CYCLES = monitor_config_pkg::WINDOW_LONG_CYCLES
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata_q,
  input wire logic [15:0] step14_value,
  input wire logic step14_load,
  input wire logic [15:0] step15_value,
  input wire logic step15_load,
  input wire logic chip_select_low,
  input wire logic crc_valid_cmd,
  input wire logic fault_active,
  output logic regmap_section1_crc_enable_q,
  output logic crc_type_ansi_q,
  output logic sclk_counter_enable_q,
  output logic frame_ignore_q,
  output logic fault_pin_q,
  output logic host_loss_pin_q
);
  import monitor_config_pkg::*;

  // ***************************************************************
  // Helpers
  // ***************************************************************

  // Window length for a watchdog code; the off code maps to zero.
  function automatic logic [TIMER_WIDTH-1:0] window_cycles(input logic [1:0] code);
    logic [TIMER_WIDTH-1:0] n;
    n = '0;
    case (host_window_t'(code))
      WINDOW_SHORT: n = TIMER_WIDTH'(WD_SHORT_CYCLES);
      WINDOW_MID: n = TIMER_WIDTH'(WD_MID_CYCLES);
      WINDOW_LONG: n = TIMER_WIDTH'(WD_LONG_CYCLES);
      default: n = '0;
    endcase
    return n;
  endfunction

  // ***************************************************************
  // Registers
  // ***************************************************************
  logic [15:0] step14_q;
  logic [15:0] step14_d;
  logic [15:0] step15_q;
  logic [15:0] step15_d;
  logic [15:0] config_q;
  logic [15:0] config_d;
  logic [15:0] rdata_d;
  logic write_ok;

  // Writes that arrive in a frame already timed out are part of the ignored remainder.
  assign write_ok = reg_wr && !frame_ignore_q;

  // Result registers load from the converter; host writes never reach them.
  always_comb
  begin
    step14_d = step14_q;
    step15_d = step15_q;
    if (step14_load)
    begin
      step14_d = step14_value;
    end
    if (step15_load)
    begin
      step15_d = step15_value;
    end
  end

  // Configuration write with reserved bits forced to zero.
  always_comb
  begin
    config_d = config_q;
    if (write_ok && reg_addr == ADDR_MONITOR_CONFIG)
    begin
      config_d = reg_wdata & CONFIG_WRITE_MASK;
    end
  end

  // Read decode; the answer appears one cycle after the read strobe.
  always_comb
  begin
    rdata_d = reg_rdata_q;
    if (reg_rd)
    begin
      if (reg_addr == ADDR_STEP14_RESULT)
      begin
        rdata_d = step14_q;
      end
      else if (reg_addr == ADDR_STEP15_RESULT)
      begin
        rdata_d = step15_q;
      end
      else if (reg_addr == ADDR_MONITOR_CONFIG)
      begin
        rdata_d = config_q & CONFIG_WRITE_MASK;
      end
      else
      begin
        rdata_d = READ_UNMAPPED;
      end
    end
  end

  // Register storage, all cleared by reset.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      step14_q <= RESULT_RESET;
      step15_q <= RESULT_RESET;
      config_q <= CONFIG_RESET;
      reg_rdata_q <= READ_UNMAPPED;
    end
    else
    begin
      step14_q <= step14_d;
      step15_q <= step15_d;
      config_q <= config_d;
      reg_rdata_q <= rdata_d;
    end
  end

  // ***************************************************************
  // Chip select synchroniser and frame timeout
  // ***************************************************************
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic cs_level_q;
  logic cs_level_d;
  logic cs_fall;
  logic cs_rise;
  logic ignore_d;
  logic timeout_done;

  // The level only changes once the second and third stages agree, filtering one-cycle glitches.
  always_comb
  begin
    cs_level_d = cs_level_q;
    if (cs_s2_q == cs_s3_q)
    begin
      cs_level_d = cs_s3_q;
    end
  end

  assign cs_fall = cs_level_q && !cs_level_d;
  assign cs_rise = !cs_level_q && cs_level_d;

  // Once the timer expires the frame is dropped until chip select rises again.
  always_comb
  begin
    ignore_d = frame_ignore_q;
    if (cs_rise || cs_fall)
    begin
      ignore_d = 1'b0;
    end
    // The timer keeps its done flag after chip select rises, so only a selected frame may be dropped.
    else if (timeout_done && config_q[BIT_TIMEOUT_EN] && !cs_level_q)
    begin
      ignore_d = 1'b1;
    end
  end

  cycle_timer frame_timer
  (
    .core_clk(core_clk),
    .rst(rst),
    .run(config_q[BIT_TIMEOUT_EN] && !cs_level_q),
    .restart(cs_fall),
    .limit(TIMER_WIDTH'(TIMEOUT_CYCLES)),
    .done_q(timeout_done)
  );

  // Chip select idles high, so the synchroniser resets to the deselected level.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      cs_level_q <= 1'b1;
      frame_ignore_q <= 1'b0;
    end
    else
    begin
      cs_s1_q <= chip_select_low;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      cs_level_q <= cs_level_d;
      frame_ignore_q <= ignore_d;
    end
  end

  // ***************************************************************
  // Host-loss watchdog and output pins
  // ***************************************************************
  logic [1:0] window_code;
  logic host_lost_q;
  logic host_lost_d;
  logic wd_done;
  logic fault_pin_d;
  logic host_loss_pin_d;

  assign window_code = config_q[WINDOW_HI:WINDOW_LO];

  // Every valid command restarts the window; the off code holds the timer cleared.
  cycle_timer host_watchdog
  (
    .core_clk(core_clk),
    .rst(rst),
    .run(window_code != WINDOW_OFF),
    .restart(crc_valid_cmd || window_code == WINDOW_OFF),
    .limit(window_cycles(window_code)),
    .done_q(wd_done)
  );

  // Host loss latches until the host turns detection off, which is the only way to clear it.
  always_comb
  begin
    host_lost_d = host_lost_q;
    if (window_code == WINDOW_OFF)
    begin
      host_lost_d = 1'b0;
    end
    else if (wd_done)
    begin
      host_lost_d = 1'b1;
    end
  end

  // Pin levels follow the chosen polarity: active level equals the polarity bit.
  always_comb
  begin
    fault_pin_d = config_q[BIT_FAULT_POLARITY] ? fault_active : !fault_active;
    host_loss_pin_d = config_q[BIT_HOST_LOSS_POLARITY] ? host_lost_d : !host_lost_d;
  end

  // Output flops; after reset both pins sit at the inactive low-polarity level, high.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      host_lost_q <= 1'b0;
      fault_pin_q <= 1'b1;
      host_loss_pin_q <= 1'b1;
      regmap_section1_crc_enable_q <= 1'b0;
      crc_type_ansi_q <= 1'b0;
      sclk_counter_enable_q <= 1'b0;
    end
    else
    begin
      host_lost_q <= host_lost_d;
      fault_pin_q <= fault_pin_d;
      host_loss_pin_q <= host_loss_pin_d;
      regmap_section1_crc_enable_q <= config_d[BIT_SECTION1_CRC_EN];
      crc_type_ansi_q <= config_d[BIT_CRC_TYPE];
      sclk_counter_enable_q <= config_d[BIT_SCLK_COUNTER_EN];
    end
  end
endmodule

// file: test/monitor_config_chk.sv
// Checker of the monitor configuration slice ports.
`timescale 1ns/100ps
module monitor_config_chk
  import monitor_config_pkg::*;
(
  input wire logic core_clk, rst, reg_wr, reg_rd, step14_load, step15_load,
  input wire logic chip_select_low, fault_active, frame_ignore_q, fault_pin_q,
  input wire logic regmap_section1_crc_enable_q, crc_type_ansi_q, sclk_counter_enable_q,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata, reg_rdata_q, step14_value, step15_value
);
  // All checks share the core clock and rest during reset.
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // A config write is only taken while the frame is not being dropped.
  sequence s_cfg_wr;
    reg_wr && reg_addr == 8'h40 && !frame_ignore_q;
  endsequence
  property p_crc_en; s_cfg_wr |=> regmap_section1_crc_enable_q == $past(reg_wdata[15]); endproperty
  a_crc_en: assert property (p_crc_en) else $error("section CRC enable wrong");
  property p_crc_type; s_cfg_wr |=> crc_type_ansi_q == $past(reg_wdata[14]); endproperty
  a_crc_type: assert property (p_crc_type) else $error("polynomial select wrong");
  property p_sclk; s_cfg_wr |=> sclk_counter_enable_q == $past(reg_wdata[13]); endproperty
  a_sclk: assert property (p_sclk) else $error("clock counter enable wrong");
  property p_rsv; reg_rd && reg_addr == 8'h40 |=> (reg_rdata_q & 16'h0ef8) == 16'h0000; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  // Result read one cycle after its load returns the loaded value whole.
  property p_res14;
    step14_load ##1 (reg_rd && reg_addr == 8'h2e && !step14_load) |=> reg_rdata_q == $past(step14_value, 2);
  endproperty
  a_res14: assert property (p_res14) else $error("step 14 result wrong");
  property p_res15;
    step15_load ##1 (reg_rd && reg_addr == 8'h2f && !step15_load) |=> reg_rdata_q == $past(step15_value, 2);
  endproperty
  a_res15: assert property (p_res15) else $error("step 15 result wrong");
  property p_drop; reg_wr && frame_ignore_q |=> $stable(crc_type_ansi_q) && $stable(sclk_counter_enable_q); endproperty
  a_drop: assert property (p_drop) else $error("write taken in dropped frame");
  property p_idle; chip_select_low [*6] |-> !frame_ignore_q; endproperty
  a_idle: assert property (p_idle) else $error("frame dropped while deselected");
  // A write one edge earlier may flip the polarity together with the fault, so that case is left out.
  property p_fault; $changed(fault_active) && !$past(reg_wr) |=> $changed(fault_pin_q); endproperty
  a_fault: assert property (p_fault) else $error("fault pin did not follow");
  c_drop: cover property ($rose(frame_ignore_q));
  c_res14: cover property (step14_load ##1 reg_rd);
  c_cfg: cover property (s_cfg_wr);
  c_res15: cover property (step15_load ##1 reg_rd);
endmodule

// file: test/host_model.sv
// Behavioural host that frames chip select and flags good commands.
`timescale 1ns/100ps
module host_model
(
  input wire logic core_clk,
  output logic chip_select_low,
  output logic crc_valid_cmd
);
  // Chip select idles high between frames.
  initial
  begin
    chip_select_low = 1'b1;
    crc_valid_cmd = 1'b0;
  end
  // Holds chip select low for n cycles; a long hold overruns the frame limit.
  task automatic frame(input int n);
    @(posedge core_clk);
    #1 chip_select_low = 1'b0;
    repeat (n) @(posedge core_clk);
    #1 chip_select_low = 1'b1;
  endtask
  // One command, shown by a one-cycle pulse on crc_valid_cmd.
  task automatic cmd();
    @(posedge core_clk);
    #1 crc_valid_cmd = 1'b1;
    @(posedge core_clk);
    #1 crc_valid_cmd = 1'b0;
  endtask
endmodule

// file: test/tb_top.sv
// Self-checking bench of the monitor configuration slice.
`timescale 1ns/100ps
module tb_top;
  import monitor_config_pkg::*;
  logic core_clk, rst, reg_wr, reg_rd, step14_load, step15_load, fault_active, rd_p;
  logic chip_select_low, crc_valid_cmd, frame_ignore_q, fault_pin_q, host_loss_pin_q, crc_en, crc_ansi, sclk_en;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata_q, step14_value, step15_value, d;
  logic [15:0] exp_q[$];
  int failures, samples_checked, seed;
  monitor_config_regs #(.TIMEOUT_CYCLES(20), .WD_SHORT_CYCLES(10), .WD_MID_CYCLES(20), .WD_LONG_CYCLES(40)) i_dut
  (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .step14_value(step14_value), .step14_load(step14_load), .step15_value(step15_value),
    .step15_load(step15_load), .chip_select_low(chip_select_low), .crc_valid_cmd(crc_valid_cmd),
    .fault_active(fault_active), .regmap_section1_crc_enable_q(crc_en), .crc_type_ansi_q(crc_ansi),
    .sclk_counter_enable_q(sclk_en), .frame_ignore_q(frame_ignore_q), .fault_pin_q(fault_pin_q),
    .host_loss_pin_q(host_loss_pin_q));
  host_model i_host (.core_clk(core_clk), .chip_select_low(chip_select_low), .crc_valid_cmd(crc_valid_cmd));
  // ****************************************
  // Clock, checks and closing
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Read data lands one edge after the strobe, so it is taken at the next falling edge.
  always @(posedge core_clk) rd_p <= reg_rd;
  always @(negedge core_clk)
  begin
    if (rd_p && exp_q.size() > 0)
      check(reg_rdata_q, exp_q.pop_front());
    else if (rd_p)
    begin
      failures++;
      $display("Error at %0t: read data with no expectation", $time);
    end
  end
  task automatic end_sim();
    // Reads that never produced an answer count as mismatches.
    failures += exp_q.size();
    $display("Checks %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #500000 failures++;
    end_sim();
  end
  // One bus cycle; for a read v is the expected data, l pulses the result loads.
  task automatic op(input logic w, r, input logic [7:0] a, input logic [15:0] v, input logic [1:0] l = 2'b00);
    @(posedge core_clk);
    #1;
    {step15_load, step14_load} = l;
    step14_value = v;
    step15_value = ~v;
    reg_wr = w;
    reg_rd = r;
    reg_addr = a;
    reg_wdata = v;
    if (r) exp_q.push_back(v);
  endtask
  task automatic idle(input int n);
    op(0, 0, 8'h00, 16'h0000);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    seed = 18;
    {reg_wr, reg_rd, step14_load, step15_load, fault_active} = 5'h00;
    {reg_addr, reg_wdata, step14_value, step15_value} = 56'h0;
    rst = 1'b1;
    repeat (4) @(posedge core_clk);
    #1 rst = 1'b0;
    op(0, 1, 8'h2e, 16'h0000);
    op(0, 1, 8'h2f, 16'h0000);
    op(0, 1, 8'h40, 16'h0000);
    op(1, 0, 8'h2e, 16'h1234);
    op(0, 1, 8'h2e, 16'h0000);
    op(0, 1, 8'h41, 16'h0000);
    // Random config words back to back with their read-back.
    repeat (8)
    begin
      d = 16'($random(seed));
      op(1, 0, 8'h40, d);
      fault_active = d[5];
      op(0, 1, 8'h40, d & 16'hf107);
    end
    for (int k = 0; k < 2; k++)
    begin
      d = k ? 16'($random(seed)) : 16'h8000;
      op(0, 0, 8'h00, d, 2'b11);
      op(0, 1, k ? 8'h2f : 8'h2e, k ? ~d : d);
      op(0, 1, k ? 8'h2e : 8'h2f, k ? d : ~d);
    end
    // Overlong frame: writes are dropped until chip select rises.
    op(1, 0, 8'h40, 16'h1000);
    idle(1);
    fork
      i_host.frame(30);
      begin
        repeat (27) @(posedge core_clk);
        #1 check(frame_ignore_q, 1);
        op(1, 0, 8'h40, 16'h6000);
        idle(0);
      end
    join
    op(0, 1, 8'h40, 16'h1000);
    idle(0);
    i_host.frame(8);
    check(frame_ignore_q, 0);
    op(1, 0, 8'h40, 16'h0100);
    fault_active = 1'b1;
    idle(2);
    check(fault_pin_q, 1);
    op(1, 0, 8'h40, 16'h0000);
    idle(2);
    check(fault_pin_q, 0);
    fault_active = 1'b0;
    for (int k = 1; k < 4; k++)
    begin
      op(1, 0, 8'h40, 16'(k));
      idle(0);
      repeat (3) i_host.cmd();
      idle((10 << (k - 1)) - 6);
      check(host_loss_pin_q, 1);
      idle(10);
      check(host_loss_pin_q, 0);
      i_host.cmd();
      check(host_loss_pin_q, 0);
      op(1, 0, 8'h40, 16'h0000);
      idle(3);
      check(host_loss_pin_q, 1);
    end
    op(1, 0, 8'h40, 16'h0004);
    idle(2);
    check(host_loss_pin_q, 0);
    idle(2);
    end_sim();
  end
endmodule
bind monitor_config_regs monitor_config_chk i_chk (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .step14_load(step14_load), .step15_load(step15_load), .chip_select_low(chip_select_low),
  .fault_active(fault_active), .frame_ignore_q(frame_ignore_q), .fault_pin_q(fault_pin_q),
  .regmap_section1_crc_enable_q(regmap_section1_crc_enable_q), .crc_type_ansi_q(crc_type_ansi_q),
  .sclk_counter_enable_q(sclk_counter_enable_q), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata_q(reg_rdata_q), .step14_value(step14_value), .step15_value(step15_value));
